/* verilog/nibble_cpu_regs_stack.sv */
`timescale 1ns/1ns
module nibble_cpu_regs_stack
  import nibble_regs_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  input  wire op_t               op_i,
  input  wire logic [NIB_W-1:0]  imm_i,
  input  wire logic [NIB_W-1:0]  mem_i,
  input  wire logic [BIT_W-1:0]  bit_sel_i,
  input  wire logic [PC_W-1:0]   target_i,
  input  wire logic [DP_W-1:0]   data_pointer_i,
  input  wire logic              ram_backup_ret_i,
  output logic [NIB_W-1:0]       acc_o,
  output logic [NIB_W-1:0]       aux_o,
  output logic [WIDE_W-1:0]      wide_o,
  output logic [PAGE_W-1:0]      page_ptr_o,
  output logic                   carry_flag_o,
  output logic                   skip_flag_o,
  output logic [SP_W-1:0]        stack_level_ptr_o,
  output logic [PC_W-1:0]        pc_o,
  output logic                   global_irq_enable_o,
  output logic                   mem_we_o,
  output logic [NIB_W-1:0]       mem_wdata_o,
  output logic                   dp_restore_o,
  output logic [DP_W-1:0]        data_pointer_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [NIB_W-1:0] bit_mask(input logic [BIT_W-1:0] sel);
    bit_mask = NIB_ONE << sel;
  endfunction : bit_mask

  // offset wraps to 0 and carries into the page bits
  function automatic logic [PC_W-1:0] pc_next(input logic [PC_W-1:0] pc);
    pc_next = pc + PC_W'(1);
  endfunction : pc_next

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [NIB_W-1:0]  accumulator_nibble_q, accumulator_nibble_d;
  logic [NIB_W-1:0]  aux_nibble_reg_q, aux_nibble_reg_d;
  logic [WIDE_W-1:0] wide_byte_reg_q, wide_byte_reg_d;
  logic [PAGE_W-1:0] page_pointer_reg_q, page_pointer_reg_d;
  logic              carry_flag_q, carry_flag_d;
  logic              skip_flag_q, skip_flag_d;
  logic [SP_W-1:0]   stack_level_ptr_q, stack_level_ptr_d;
  logic [PC_W-1:0]   pc_q, pc_d;
  logic              global_irq_enable_q, global_irq_enable_d;
  logic              mem_we_q, mem_we_d;
  logic [NIB_W-1:0]  mem_wdata_q, mem_wdata_d;
  logic              dp_restore_q, dp_restore_d;
  logic [DP_W-1:0]   data_pointer_q, data_pointer_d;
  logic [SAVE_W-1:0] interrupt_save_stage_q, interrupt_save_stage_d;
  logic [PC_W-1:0]   return_stack_entry [DEPTH];
  logic              push;
  logic [NIB_W:0]    sum;
  logic [NIB_W-1:0]  addend;
  logic              carry_in;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    accumulator_nibble_d   = accumulator_nibble_q;
    aux_nibble_reg_d       = aux_nibble_reg_q;
    wide_byte_reg_d        = wide_byte_reg_q;
    page_pointer_reg_d     = page_pointer_reg_q;
    carry_flag_d           = carry_flag_q;
    skip_flag_d            = 1'b0;
    stack_level_ptr_d      = stack_level_ptr_q;
    pc_d                   = pc_q;
    global_irq_enable_d    = global_irq_enable_q;
    mem_we_d               = 1'b0;
    mem_wdata_d            = mem_wdata_q;
    dp_restore_d           = 1'b0;
    data_pointer_d         = data_pointer_q;
    interrupt_save_stage_d = interrupt_save_stage_q;
    push                   = 1'b0;
    addend                 = (op_i == OP_ADD_IMM) ? imm_i : mem_i;
    carry_in               = (op_i == OP_ADD_CARRY) ? carry_flag_q : 1'b0;
    sum = {1'b0, accumulator_nibble_q} + {1'b0, addend} + {4'h0, carry_in};
    case (op_i)
      OP_NOP:           skip_flag_d = skip_flag_q;
      OP_STEP:          pc_d = pc_next(pc_q);
      OP_JUMP:          pc_d = target_i;
      OP_CALL, OP_SPECIAL_CALL: begin
        push = 1'b1;
        pc_d = target_i;
      end
      // in-page address from page pointer and acc
      OP_TABLE_LOOKUP, OP_CALL_ACC: begin
        push = 1'b1;
        pc_d = {target_i[PC_W-1:OFS_W], page_pointer_reg_q, accumulator_nibble_q};
      end
      OP_BRANCH_ACC:
        pc_d = {target_i[PC_W-1:OFS_W], page_pointer_reg_q, accumulator_nibble_q};
      OP_RET: begin
        pc_d              = return_stack_entry[stack_level_ptr_q];
        stack_level_ptr_d = stack_level_ptr_q - SP_STEP;
      end
      OP_IRQ_ENTRY: begin
        push                   = 1'b1;
        pc_d                   = target_i;
        global_irq_enable_d    = 1'b0;
        interrupt_save_stage_d = {data_pointer_i, carry_flag_q, skip_flag_q,
                                  accumulator_nibble_q, aux_nibble_reg_q};
      end
      OP_IRQ_RET: begin
        pc_d              = return_stack_entry[stack_level_ptr_q];
        stack_level_ptr_d = stack_level_ptr_q - SP_STEP;
        {data_pointer_d, carry_flag_d, skip_flag_d, accumulator_nibble_d,
         aux_nibble_reg_d} = interrupt_save_stage_q;
        dp_restore_d      = 1'b1;
      end
      OP_ADD_CARRY:     {carry_flag_d, accumulator_nibble_d} = sum;
      OP_ADD_IMM, OP_ADD_MEM: accumulator_nibble_d = sum[NIB_W-1:0];
      OP_AND_MEM:       accumulator_nibble_d = accumulator_nibble_q & mem_i;
      OP_OR_MEM:        accumulator_nibble_d = accumulator_nibble_q | mem_i;
      OP_CMP_MEM:       skip_flag_d = (accumulator_nibble_q == mem_i);
      OP_SET_BIT: begin
        mem_we_d    = 1'b1;
        mem_wdata_d = mem_i | bit_mask(bit_sel_i);
      end
      OP_CLR_BIT: begin
        mem_we_d    = 1'b1;
        mem_wdata_d = mem_i & ~bit_mask(bit_sel_i);
      end
      OP_TEST_BIT:      skip_flag_d = |(mem_i & bit_mask(bit_sel_i));
      OP_ROTATE_RIGHT: begin
        carry_flag_d         = accumulator_nibble_q[0];
        accumulator_nibble_d = {carry_flag_q, accumulator_nibble_q[NIB_W-1:1]};
      end
      OP_CARRY_SET:     carry_flag_d = 1'b1;
      OP_CARRY_CLEAR:   carry_flag_d = 1'b0;
      OP_LOAD_ACC:      accumulator_nibble_d = imm_i;
      OP_LOAD_AUX:      aux_nibble_reg_d = accumulator_nibble_q;
      OP_LOAD_PAGE:     page_pointer_reg_d = imm_i[PAGE_W-1:0];
      OP_AB_TO_WIDE:    wide_byte_reg_d = {aux_nibble_reg_q, accumulator_nibble_q};
      OP_WIDE_TO_AB:    {aux_nibble_reg_d, accumulator_nibble_d} = wide_byte_reg_q;
      OP_ACC_TO_MEM: begin
        mem_we_d    = 1'b1;
        mem_wdata_d = accumulator_nibble_q;
      end
      OP_SP_READ:       accumulator_nibble_d = {1'b0, stack_level_ptr_q};
      OP_IRQ_ENABLE:    global_irq_enable_d = 1'b1;
      OP_IRQ_DISABLE:   global_irq_enable_d = 1'b0;
      default:          skip_flag_d = skip_flag_q;
    endcase
    if (push) begin
      stack_level_ptr_d = stack_level_ptr_q + SP_STEP;
    end
    // back-up return wins over any push or pop
    if (ram_backup_ret_i) begin
      stack_level_ptr_d = SP_RESET;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // wide byte and page pointer still cleared: x-free sim beats area
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      accumulator_nibble_q   <= NIB_ZERO;
      aux_nibble_reg_q       <= NIB_ZERO;
      wide_byte_reg_q        <= '0;
      page_pointer_reg_q     <= '0;
      carry_flag_q           <= 1'b0;
      skip_flag_q            <= 1'b0;
      stack_level_ptr_q      <= SP_RESET;
      pc_q                   <= '0;
      global_irq_enable_q    <= 1'b0;
      mem_we_q               <= 1'b0;
      mem_wdata_q            <= NIB_ZERO;
      dp_restore_q           <= 1'b0;
      data_pointer_q         <= '0;
      interrupt_save_stage_q <= '0;
    end else begin
      accumulator_nibble_q   <= accumulator_nibble_d;
      aux_nibble_reg_q       <= aux_nibble_reg_d;
      wide_byte_reg_q        <= wide_byte_reg_d;
      page_pointer_reg_q     <= page_pointer_reg_d;
      carry_flag_q           <= carry_flag_d;
      skip_flag_q            <= skip_flag_d;
      stack_level_ptr_q      <= stack_level_ptr_d;
      pc_q                   <= pc_d;
      global_irq_enable_q    <= global_irq_enable_d;
      mem_we_q               <= mem_we_d;
      mem_wdata_q            <= mem_wdata_d;
      dp_restore_q           <= dp_restore_d;
      data_pointer_q         <= data_pointer_d;
      interrupt_save_stage_q <= interrupt_save_stage_d;
    end
  end

  // eight entries, written at the advanced pointer
  always_ff @(posedge core_clk_i) begin
    if (push && resetn_i) begin
      return_stack_entry[stack_level_ptr_q + SP_STEP] <= pc_q;
    end
  end

  assign acc_o               = accumulator_nibble_q;
  assign aux_o               = aux_nibble_reg_q;
  assign wide_o              = wide_byte_reg_q;
  assign page_ptr_o          = page_pointer_reg_q;
  assign carry_flag_o        = carry_flag_q;
  assign skip_flag_o         = skip_flag_q;
  assign stack_level_ptr_o   = stack_level_ptr_q;
  assign pc_o                = pc_q;
  assign global_irq_enable_o = global_irq_enable_q;
  assign mem_we_o            = mem_we_q;
  assign mem_wdata_o         = mem_wdata_q;
  assign dp_restore_o        = dp_restore_q;
  assign data_pointer_o      = data_pointer_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_call_op;
    (op_i == OP_CALL) && !ram_backup_ret_i;
  endsequence
  sequence s_ret_op;
    (op_i == OP_RET) && !ram_backup_ret_i;
  endsequence

  a_add_carry_out: assert property ((op_i == OP_ADD_CARRY) |=>
    carry_flag_q == (($past(accumulator_nibble_q) + $past(mem_i) + $past(carry_flag_q)) > 15))
    else $error("carry wrong after add with carry");
  a_add_keeps_carry: assert property ((op_i inside {OP_ADD_IMM, OP_ADD_MEM}) |=>
    $stable(carry_flag_q)) else $error("plain add changed carry");
  a_rotate_right: assert property ((op_i == OP_ROTATE_RIGHT) |=>
    carry_flag_q == $past(accumulator_nibble_q[0]) && accumulator_nibble_q[3] == $past(carry_flag_q))
    else $error("rotate right wrong");
  a_carry_force: assert property ((op_i == OP_CARRY_SET) ##1 (op_i == OP_CARRY_CLEAR) |->
    carry_flag_q ##1 !carry_flag_q) else $error("carry not forced");
  a_sp_read: assert property ((op_i == OP_SP_READ) |=>
    accumulator_nibble_q == {1'b0, $past(stack_level_ptr_q)}) else $error("pointer read wrong");
  a_backup_sp: assert property (ram_backup_ret_i |=> stack_level_ptr_q == SP_RESET)
    else $error("pointer not 7 after back-up return");
  a_call_wraps: assert property (s_call_op and (stack_level_ptr_q == SP_RESET) |=>
    stack_level_ptr_q == '0) else $error("call at 7 did not wrap");
  a_call_then_ret: assert property (s_call_op ##1 s_ret_op |=>
    pc_q == $past(pc_q, 2) && stack_level_ptr_q == $past(stack_level_ptr_q, 2))
    else $error("return did not undo call");
  a_irq_restore: assert property ((op_i == OP_IRQ_ENTRY) ##1 (op_i == OP_IRQ_RET) |=>
    skip_flag_q == $past(skip_flag_q, 2) && aux_nibble_reg_q == $past(aux_nibble_reg_q, 2))
    else $error("irq context not restored");
  a_irq_clears_ie: assert property ((op_i == OP_IRQ_ENTRY) |=> !global_irq_enable_q)
    else $error("irq enable not cleared");
  a_page_wrap: assert property ((op_i == OP_STEP) && pc_q[OFS_W-1:0] == OFS_LAST |=>
    pc_q[OFS_W-1:0] == OFS_FIRST && pc_q[PC_W-1:OFS_W] == $past(pc_q[PC_W-1:OFS_W]) + 1'b1)
    else $error("page wrap wrong");
  a_call_keeps_save: assert property ((op_i inside {OP_CALL, OP_TABLE_LOOKUP}) |=>
    $stable(interrupt_save_stage_q)) else $error("save stage written by call");

endmodule : nibble_cpu_regs_stack

/* verilog/nibble_regs_pkg.sv */
package nibble_regs_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int NIB_W   = 4;
  localparam int WIDE_W  = 8;
  localparam int PAGE_W  = 3;
  localparam int SP_W    = 3;
  localparam int OFS_W   = 7;
  localparam int PC_W    = 14;
  localparam int DP_W    = 10;
  localparam int BIT_W   = 2;
  localparam int DEPTH   = 8;
  localparam int SAVE_W  = DP_W + 2 + 2 * NIB_W;

  // ----------------------------------------------------------------
  // reset and boundary values
  // ----------------------------------------------------------------
  localparam logic [SP_W-1:0]  SP_RESET  = 3'h7;
  localparam logic [SP_W-1:0]  SP_STEP   = 3'h1;
  localparam logic [OFS_W-1:0] OFS_LAST  = 7'h7F;
  localparam logic [OFS_W-1:0] OFS_FIRST = 7'h00;
  localparam logic [NIB_W-1:0] NIB_ZERO  = 4'h0;
  localparam logic [NIB_W-1:0] NIB_ONE   = 4'h1;

  // ----------------------------------------------------------------
  // operations issued by the sequencer
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_STEP, OP_JUMP, OP_CALL, OP_SPECIAL_CALL, OP_RET,
    OP_IRQ_ENTRY, OP_IRQ_RET, OP_TABLE_LOOKUP, OP_BRANCH_ACC, OP_CALL_ACC,
    OP_ADD_CARRY, OP_ADD_IMM, OP_ADD_MEM, OP_AND_MEM, OP_OR_MEM, OP_CMP_MEM,
    OP_SET_BIT, OP_CLR_BIT, OP_TEST_BIT, OP_ROTATE_RIGHT, OP_CARRY_SET,
    OP_CARRY_CLEAR, OP_LOAD_ACC, OP_LOAD_AUX, OP_LOAD_PAGE, OP_AB_TO_WIDE,
    OP_WIDE_TO_AB, OP_ACC_TO_MEM, OP_SP_READ, OP_IRQ_ENABLE, OP_IRQ_DISABLE
  } op_t;
endpackage : nibble_regs_pkg

/* dv/data_mem_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// sequencer pointer and data memory seen by the datapath
// ----------------------------------------------------------------
module data_mem_model
  import nibble_regs_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             set_en_i,
  input  wire logic [DP_W-1:0]  set_ptr_i,
  input  wire logic             we_i,
  input  wire logic [NIB_W-1:0] wdata_i,
  input  wire logic             restore_i,
  input  wire logic [DP_W-1:0]  restore_ptr_i,
  output logic      [DP_W-1:0]  data_ptr_o,
  output logic      [NIB_W-1:0] rdata_o
);
  logic [NIB_W-1:0] mem_q [0:(1<<DP_W)-1];

  // known fill so the bench can predict every read
  initial begin
    data_ptr_o = '0;
    for (int i = 0; i < (1 << DP_W); i++) begin
      mem_q[i] = 4'(i) ^ 4'hA;
    end
  end

  // restore wins over a software load in the same cycle
  always @(posedge core_clk_i) begin
    if (we_i) begin
      mem_q[data_ptr_o] <= wdata_i;
    end
    if (restore_i) begin
      data_ptr_o <= restore_ptr_i;
    end else if (set_en_i) begin
      data_ptr_o <= set_ptr_i;
    end
  end

  assign rdata_o = mem_q[data_ptr_o];
endmodule : data_mem_model

/* dv/nibble_cpu_regs_stack_bench.sv */
`timescale 1ns/1ns
module nibble_cpu_regs_stack_bench
  import nibble_regs_pkg::*;
();
  logic              core_clk, resetn, ram_ret, set_en, carry, skip, ie, we, rest;
  op_t               op;
  logic [NIB_W-1:0]  imm, acc, aux, wdata, mem_rd;
  logic [BIT_W-1:0]  bsel;
  logic [PC_W-1:0]   tgt, pc;
  logic [DP_W-1:0]   set_ptr, data_ptr, rest_ptr;
  logic [WIDE_W-1:0] wide;
  logic [PAGE_W-1:0] page;
  logic [SP_W-1:0]   lvl;
  int                bad_count, samples_checked, cycles;

  nibble_cpu_regs_stack dut (.core_clk_i(core_clk), .resetn_i(resetn), .op_i(op), .imm_i(imm),
    .mem_i(mem_rd), .bit_sel_i(bsel), .target_i(tgt), .data_pointer_i(data_ptr),
    .ram_backup_ret_i(ram_ret), .acc_o(acc), .aux_o(aux), .wide_o(wide), .page_ptr_o(page),
    .carry_flag_o(carry), .skip_flag_o(skip), .stack_level_ptr_o(lvl), .pc_o(pc),
    .global_irq_enable_o(ie), .mem_we_o(we), .mem_wdata_o(wdata), .dp_restore_o(rest),
    .data_pointer_o(rest_ptr));

  data_mem_model mem (.core_clk_i(core_clk), .set_en_i(set_en), .set_ptr_i(set_ptr), .we_i(we),
    .wdata_i(wdata), .restore_i(rest), .restore_ptr_i(rest_ptr), .data_ptr_o(data_ptr),
    .rdata_o(mem_rd));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    samples_checked++;
    if (s !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // one op, then idle; results are registered so look one edge later
  task automatic run(input op_t o, input logic [3:0] v = 4'h0, input logic [13:0] t = 14'h0,
                     input logic [1:0] b = 2'h0);
    @(posedge core_clk);
    op <= o;
    imm <= v;
    tgt <= t;
    bsel <= b;
    @(posedge core_clk);
    op <= OP_NOP;
    #1;
  endtask : run

  // two ops on consecutive edges, no idle cycle between them
  task automatic pair(input op_t o1, input op_t o2, input logic [13:0] t = 14'h0);
    @(posedge core_clk);
    op <= o1;
    tgt <= t;
    @(posedge core_clk);
    op <= o2;
    @(posedge core_clk);
    op <= OP_NOP;
    #1;
  endtask : pair

  task automatic point(input logic [9:0] p);
    @(posedge core_clk);
    set_en <= 1'b1;
    set_ptr <= p;
    @(posedge core_clk);
    set_en <= 1'b0;
    #1;
  endtask : point

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_alu();
    run(OP_CARRY_SET);
    chk("carry", 16'(carry), 16'h1);
    run(OP_LOAD_ACC, 4'h9);
    run(OP_ADD_IMM, 4'h9);
    chk("acc", 16'(acc), 16'h2);
    chk("carry", 16'(carry), 16'h1);
    run(OP_CARRY_CLEAR);
    point(10'h00F);
    run(OP_LOAD_ACC, 4'hC);
    run(OP_ADD_MEM);
    chk("acc", 16'(acc), 16'h1);
    chk("carry", 16'(carry), 16'h0);
    run(OP_CARRY_SET);
    run(OP_LOAD_ACC, 4'hE);
    run(OP_ADD_CARRY);
    chk("acc", 16'(acc), 16'h4);
    chk("carry", 16'(carry), 16'h1);
    run(OP_CARRY_CLEAR);
    chk("carry", 16'(carry), 16'h0);
    run(OP_LOAD_ACC, 4'h5);
    run(OP_ROTATE_RIGHT);
    chk("acc", 16'(acc), 16'h2);
    chk("carry", 16'(carry), 16'h1);
    run(OP_ROTATE_RIGHT);
    chk("acc", 16'(acc), 16'h9);
    chk("carry", 16'(carry), 16'h0);
  endtask : t_alu

  task automatic t_mem();
    point(10'h006);
    run(OP_LOAD_ACC, 4'hF);
    run(OP_AND_MEM);
    chk("acc", 16'(acc), 16'hC);
    run(OP_LOAD_ACC, 4'h3);
    run(OP_OR_MEM);
    chk("acc", 16'(acc), 16'hF);
    run(OP_LOAD_ACC, 4'hC);
    run(OP_CMP_MEM);
    run(OP_NOP);
    chk("skip", 16'(skip), 16'h1);
    run(OP_SET_BIT, 4'h0, 14'h0, 2'h1);
    chk("we", 16'(we), 16'h1);
    chk("wdata", 16'(wdata), 16'hE);
    run(OP_TEST_BIT, 4'h0, 14'h0, 2'h1);
    chk("skip", 16'(skip), 16'h1);
    run(OP_TEST_BIT, 4'h0, 14'h0, 2'h0);
    chk("skip", 16'(skip), 16'h0);
    run(OP_ACC_TO_MEM);
    chk("wdata", 16'(wdata), 16'hC);
    run(OP_CLR_BIT, 4'h0, 14'h0, 2'h2);
    chk("wdata", 16'(wdata), 16'h8);
  endtask : t_mem

  task automatic t_wide();
    run(OP_LOAD_ACC, 4'h3);
    run(OP_LOAD_AUX);
    chk("aux", 16'(aux), 16'h3);
    run(OP_LOAD_ACC, 4'hC);
    run(OP_AB_TO_WIDE);
    chk("wide", 16'(wide), 16'h3C);
    run(OP_LOAD_ACC, 4'h0);
    run(OP_LOAD_AUX);
    run(OP_WIDE_TO_AB);
    chk("acc", 16'(acc), 16'hC);
    chk("aux", 16'(aux), 16'h3);
  endtask : t_wide

  // nine calls: the last one wraps and destroys the oldest return
  task automatic t_stack();
    run(OP_CALL, 4'h0, 14'h0020);
    chk("lvl", 16'(lvl), 16'h0);
    @(posedge core_clk);
    ram_ret <= 1'b1;
    @(posedge core_clk);
    ram_ret <= 1'b0;
    #1;
    chk("lvl", 16'(lvl), 16'h7);
    run(OP_JUMP, 4'h0, 14'h0040);
    for (int k = 0; k < 9; k++) begin
      run(OP_CALL, 4'h0, 14'h0100 + 14'(k * 16));
      chk("lvl", 16'(lvl), 16'(k % 8));
    end
    chk("pc", 16'(pc), 16'h0180);
    run(OP_RET);
    chk("pc", 16'(pc), 16'h0170);
    chk("lvl", 16'(lvl), 16'h7);
    run(OP_SP_READ);
    chk("acc", 16'(acc), 16'h7);
    run(OP_RET);
    chk("pc", 16'(pc), 16'h0160);
    run(OP_RET);
    chk("lvl", 16'(lvl), 16'h5);
  endtask : t_stack

  task automatic t_page();
    run(OP_JUMP, 4'h0, 14'h007F);
    run(OP_STEP);
    chk("pc", 16'(pc), 16'h0080);
    run(OP_LOAD_PAGE, 4'h5);
    chk("page", 16'(page), 16'h5);
    run(OP_LOAD_ACC, 4'hA);
    run(OP_BRANCH_ACC, 4'h0, 14'h0380);
    chk("pc", 16'(pc), 16'h03DA);
    run(OP_TABLE_LOOKUP, 4'h0, 14'h0200);
    chk("pc", 16'(pc), 16'h025A);
    chk("lvl", 16'(lvl), 16'h6);
    run(OP_RET);
    chk("pc", 16'(pc), 16'h03DA);
  endtask : t_page

  task automatic t_irq();
    point(10'h123);
    run(OP_IRQ_ENABLE);
    chk("ie", 16'(ie), 16'h1);
    run(OP_CARRY_SET);
    run(OP_LOAD_ACC, 4'h4);
    run(OP_LOAD_AUX);
    run(OP_LOAD_ACC, 4'h9);
    run(OP_CMP_MEM);
    // one extra level for the handler; with its call all eight entries are in use
    run(OP_IRQ_ENTRY, 4'h0, 14'h0080);
    chk("ie", 16'(ie), 16'h0);
    run(OP_CARRY_CLEAR);
    run(OP_LOAD_ACC, 4'h0);
    run(OP_LOAD_AUX);
    point(10'h000);
    run(OP_CALL, 4'h0, 14'h0300);
    run(OP_RET);
    run(OP_IRQ_RET);
    chk("rest", 16'(rest), 16'h1);
    chk("rptr", 16'(rest_ptr), 16'h0123);
    chk("acc", 16'(acc), 16'h9);
    chk("aux", 16'(aux), 16'h4);
    chk("carry", 16'(carry), 16'h1);
    chk("skip", 16'(skip), 16'h1);
    chk("pc", 16'(pc), 16'h03DA);
  endtask : t_irq

  // back-to-back ops, the other call flavours and irq disable
  task automatic t_pairs();
    pair(OP_CARRY_SET, OP_CARRY_CLEAR);
    chk("carry", 16'(carry), 16'h0);
    pair(OP_CALL, OP_RET, 14'h0300);
    chk("pc", 16'(pc), 16'h03DA);
    chk("lvl", 16'(lvl), 16'h5);
    run(OP_CMP_MEM);
    pair(OP_IRQ_ENTRY, OP_IRQ_RET, 14'h0080);
    chk("skip", 16'(skip), 16'h1);
    chk("acc", 16'(acc), 16'h9);
    chk("pc", 16'(pc), 16'h03DA);
    run(OP_IRQ_ENABLE);
    run(OP_IRQ_DISABLE);
    chk("ie", 16'(ie), 16'h0);
    run(OP_SPECIAL_CALL, 4'h0, 14'h0100);
    chk("pc", 16'(pc), 16'h0100);
    run(OP_CALL_ACC, 4'h0, 14'h0180);
    chk("pc", 16'(pc), 16'h01D9);
    chk("lvl", 16'(lvl), 16'h7);
    run(OP_RET);
    chk("pc", 16'(pc), 16'h0100);
  endtask : t_pairs

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // generous ceiling, the sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    resetn = 1'b0;
    op = OP_NOP;
    imm = 4'h0;
    bsel = 2'h0;
    tgt = 14'h0;
    ram_ret = 1'b0;
    set_en = 1'b0;
    set_ptr = 10'h0;
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    chk("lvl", 16'(lvl), 16'h7);
    t_alu();
    t_mem();
    t_wide();
    t_stack();
    t_page();
    t_irq();
    t_pairs();
    summarize();
  end
endmodule : nibble_cpu_regs_stack_bench
